// file: rtl/scc_consts.vh
// constants for the scaled curve channel
`ifndef SCC_CONSTS_VH
`define SCC_CONSTS_VH

// ----------------------------------------------------------------
// fixed-point format: one lsb is 0.00001 of a unit
// ----------------------------------------------------------------
`define SCC_VAL_W        48
`define SCC_ONE          96'h0000_0000_0000_0000_0001_86a0
`define SCC_NPT          20

// ----------------------------------------------------------------
// timing: update cycle and filter time constant in 5 ms steps
// ----------------------------------------------------------------
`define SCC_CLK_KHZ      25000
`define SCC_STEP_MS      5
`define SCC_STEP_CYC     (`SCC_STEP_MS * `SCC_CLK_KHZ)
`define SCC_CYCLE_W      11
`define SCC_TAU_W        20
`define SCC_CYCLE_DEF    11'h01e
`define SCC_TAU_DEF      20'h000c8

// ----------------------------------------------------------------
// setting defaults for the configuring side
// ----------------------------------------------------------------
`define SCC_MIN_DEF      48'h0000_0000_0000
`define SCC_MAX_DEF      48'h0000_0000_0000
`define SCC_PT1_IN_DEF   48'h0000_0000_0000
`define SCC_PT2_IN_DEF   48'h0000_0001_86a0
`define SCC_PT_OUT_DEF   48'h0000_0000_0000

// ----------------------------------------------------------------
// result handling modes
// ----------------------------------------------------------------
`define SCC_RND_FLOAT    2'h0
`define SCC_RND_FLOOR    2'h1
`define SCC_RND_CEIL     2'h2
`define SCC_RND_NEAREST  2'h3

`endif

// file: rtl/scc_div.v
// unsigned restoring divider, one quotient bit per clock
`timescale 1ns/1ns
module scc_div
#(
  parameter N = 96
)
(
  // clock and reset
  input  wire         i_clk,
  input  wire         i_reset,
  // request
  input  wire         i_start,
  input  wire [N-1:0] i_num,
  input  wire [N-1:0] i_den,
  // answer
  output reg  [N-1:0] o_quo,
  output reg  [N-1:0] o_rem,
  output reg          o_done
);

  reg  [N-1:0] den_q;
  reg  [7:0]   cnt_q;
  reg          busy_q;
  wire [N:0]   rem_sh = {o_rem, o_quo[N-1]};
  wire [N:0]   rem_df = rem_sh - {1'b0, den_q};

  always @(posedge i_clk)
  begin
    if (i_reset)
    begin
      o_quo  <= {N{1'b0}};
      o_rem  <= {N{1'b0}};
      den_q  <= {N{1'b0}};
      cnt_q  <= 8'h00;
      busy_q <= 1'b0;
      o_done <= 1'b0;
    end
    else
    begin
      o_done <= 1'b0;
      if (i_start)
      begin
        o_quo  <= i_num;
        o_rem  <= {N{1'b0}};
        den_q  <= i_den;
        cnt_q  <= N[7:0];
        busy_q <= 1'b1;
      end
      else if (busy_q)
      begin
        if (!rem_df[N])
        begin
          o_rem <= rem_df[N-1:0];
          o_quo <= {o_quo[N-2:0], 1'b1};
        end
        else
        begin
          o_rem <= rem_sh[N-1:0];
          o_quo <= {o_quo[N-2:0], 1'b0};
        end
        cnt_q <= cnt_q - 8'h01;
        if (cnt_q == 8'h01)
        begin
          busy_q <= 1'b0;
          o_done <= 1'b1;
        end
      end
    end
  end

endmodule

// file: rtl/scc_seg.v
// picks the curve segment that brackets the input
`timescale 1ns/1ns
module scc_seg
#(
  parameter W   = 48,
  parameter NPT = 20
)
(
  // input value and curve points
  input  wire signed [W-1:0]     i_x,
  input  wire        [NPT*W-1:0] i_pt_in,
  input  wire        [NPT*W-1:0] i_pt_out,
  input  wire        [NPT-1:0]   i_pt_used,
  // bracketing points
  output reg  signed [W-1:0]     o_lo_in,
  output reg  signed [W-1:0]     o_hi_in,
  output reg  signed [W-1:0]     o_lo_out,
  output reg  signed [W-1:0]     o_hi_out
);

  integer i;
  integer prev;
  integer lo;
  integer hi;

  // outside the points the end segment is extended
  always @*
  begin
    prev = 0;
    lo   = 0;
    hi   = 1;
    for (i = 1; i < NPT; i = i + 1)
    begin
      if (i_pt_used[i] || i == 1)
      begin
        if (i_x >= $signed(i_pt_in[prev*W +: W]))
        begin
          lo = prev;
          hi = i;
        end
        prev = i;
      end
    end
    o_lo_in  = i_pt_in[lo*W +: W];
    o_hi_in  = i_pt_in[hi*W +: W];
    o_lo_out = i_pt_out[lo*W +: W];
    o_hi_out = i_pt_out[hi*W +: W];
  end

endmodule

// file: rtl/scc_top.v
// scaled curve channel: filter, range check, curve scaling, rounding
// Behaviour
// - flag only when range signalling enabled
// - flag when input below signed minimum
// - flag when input above maximum, default zero
// - optional first-order low-pass before checking, scaling
// - flag is a plain binary output
// - lost input freezes last valid value
// - refresh once per update cycle, 5 ms steps
// - float, floor, ceiling or nearest result handling
// - two input breakpoints, defaults zero and one
// - output equals point value at breakpoint
// - up to twenty points, extras enabled individually
// - current input and output readable
// - processing only while curve activated
// - time constant in 5 ms steps, default 1 s
`timescale 1ns/1ns
`include "scc_consts.vh"
module scc_top
#(
  parameter W        = `SCC_VAL_W,
  parameter NPT      = `SCC_NPT,
  parameter STEP_CYC = `SCC_STEP_CYC
)
(
  // clock and reset
  input  wire                       i_clk,
  input  wire                       i_reset,
  // configuration
  input  wire                       i_enable,
  input  wire                       i_filt_en,
  input  wire                       i_oor_en,
  input  wire [`SCC_TAU_W-1:0]      i_tau_steps,
  input  wire [`SCC_CYCLE_W-1:0]    i_cycle_steps,
  input  wire [1:0]                 i_round_mode,
  input  wire signed [W-1:0]        i_min,
  input  wire signed [W-1:0]        i_max,
  // curve points
  input  wire [NPT*W-1:0]           i_pt_in,
  input  wire [NPT*W-1:0]           i_pt_out,
  input  wire [NPT-1:0]             i_pt_used,
  // measured input
  input  wire signed [W-1:0]        i_in_value,
  input  wire                       i_in_valid,
  // indications
  output reg  signed [W-1:0]        o_curve_in,
  output reg  signed [W-1:0]        o_curve_out,
  output reg                        o_oor,
  output reg                        o_update
);

  localparam P = 2 * W;

  localparam S_IDLE = 3'h0;
  localparam S_FILT = 3'h1;
  localparam S_SEG  = 3'h2;
  localparam S_INT  = 3'h3;
  localparam S_RND  = 3'h4;
  localparam S_RNDW = 3'h5;
  localparam S_FIN  = 3'h6;

  // ----------------------------------------------------------------
  // magnitude helper
  // ----------------------------------------------------------------
  function [P-1:0] mag;
    input signed [P-1:0] v;
    begin
      mag = v[P-1] ? (~v + {{(P-1){1'b0}}, 1'b1}) : v;
    end
  endfunction

  // ----------------------------------------------------------------
  // update cycle timer
  // ----------------------------------------------------------------
  reg  [31:0]             step_cnt_q;
  reg  [`SCC_CYCLE_W-1:0] cyc_cnt_q;
  reg                     tick_q;
  wire [`SCC_CYCLE_W-1:0] cyc_len = (i_cycle_steps == {`SCC_CYCLE_W{1'b0}}) ?
                                    {{(`SCC_CYCLE_W-1){1'b0}}, 1'b1} : i_cycle_steps;

  always @(posedge i_clk)
  begin
    if (i_reset || !i_enable)
    begin
      step_cnt_q <= 32'h0000_0000;
      cyc_cnt_q  <= {`SCC_CYCLE_W{1'b0}};
      tick_q     <= 1'b0;
    end
    else
    begin
      tick_q <= 1'b0;
      if (step_cnt_q == STEP_CYC - 1)
      begin
        step_cnt_q <= 32'h0000_0000;
        if (cyc_cnt_q >= cyc_len - {{(`SCC_CYCLE_W-1){1'b0}}, 1'b1})
        begin
          cyc_cnt_q <= {`SCC_CYCLE_W{1'b0}};
          tick_q    <= 1'b1;
        end
        else
        begin
          cyc_cnt_q <= cyc_cnt_q + {{(`SCC_CYCLE_W-1){1'b0}}, 1'b1};
        end
      end
      else
      begin
        step_cnt_q <= step_cnt_q + 32'h0000_0001;
      end
    end
  end

  // ----------------------------------------------------------------
  // segment select and shared divider
  // ----------------------------------------------------------------
  wire signed [W-1:0] lo_in;
  wire signed [W-1:0] hi_in;
  wire signed [W-1:0] lo_out;
  wire signed [W-1:0] hi_out;
  wire [P-1:0]        div_quo;
  wire [P-1:0]        div_rem;
  wire                div_done;
  reg                 div_start_q;
  reg  [P-1:0]        div_num_q;
  reg  [P-1:0]        div_den_q;

  scc_seg #(
    .W   (W),
    .NPT (NPT)
  ) u_seg (
    .i_x       (o_curve_in),
    .i_pt_in   (i_pt_in),
    .i_pt_out  (i_pt_out),
    .i_pt_used (i_pt_used),
    .o_lo_in   (lo_in),
    .o_hi_in   (hi_in),
    .o_lo_out  (lo_out),
    .o_hi_out  (hi_out)
  );

  scc_div #(
    .N (P)
  ) u_div (
    .i_clk   (i_clk),
    .i_reset (i_reset),
    .i_start (div_start_q),
    .i_num   (div_num_q),
    .i_den   (div_den_q),
    .o_quo   (div_quo),
    .o_rem   (div_rem),
    .o_done  (div_done)
  );

  // ----------------------------------------------------------------
  // datapath terms
  // ----------------------------------------------------------------
  wire signed [P-1:0] in_ext   = {{W{i_in_value[W-1]}}, i_in_value};
  wire signed [P-1:0] x_ext    = {{W{o_curve_in[W-1]}}, o_curve_in};
  wire signed [P-1:0] filt_dif = in_ext - x_ext;
  wire signed [P-1:0] dx       = x_ext - {{W{lo_in[W-1]}}, lo_in};
  wire signed [P-1:0] dy       = {{W{hi_out[W-1]}}, hi_out} - {{W{lo_out[W-1]}}, lo_out};
  wire signed [P-1:0] dxp      = {{W{hi_in[W-1]}}, hi_in} - {{W{lo_in[W-1]}}, lo_in};
  wire signed [2*P-1:0] prod_w = dx * dy;
  wire signed [P-1:0] prod     = prod_w[P-1:0];
  wire [P-1:0]        dt_ext   = {{(P-`SCC_CYCLE_W){1'b0}}, cyc_len};
  wire [P-1:0]        tau_ext  = {{(P-`SCC_TAU_W){1'b0}}, i_tau_steps};
  wire [2*P-1:0]      fnum_w   = mag(filt_dif) * dt_ext;
  wire [P-1:0]        rem2     = {div_rem[P-2:0], 1'b0};

  // ----------------------------------------------------------------
  // processing sequence
  // ----------------------------------------------------------------
  reg  [2:0]          state_q;
  reg                 neg_q;
  reg                 init_q;
  reg  signed [W-1:0] interp_q;
  reg  [P-1:0]        rnd_mag;
  reg  signed [P-1:0] rnd_val;
  reg  signed [P-1:0] step_val;

  // rounded magnitude and signed results
  always @*
  begin
    rnd_mag = div_quo;
    case (i_round_mode)
      `SCC_RND_FLOOR:
        if (neg_q && div_rem != {P{1'b0}})
          rnd_mag = div_quo + {{(P-1){1'b0}}, 1'b1};
      `SCC_RND_CEIL:
        if (!neg_q && div_rem != {P{1'b0}})
          rnd_mag = div_quo + {{(P-1){1'b0}}, 1'b1};
      `SCC_RND_NEAREST:
        if (rem2 >= `SCC_ONE)
          rnd_mag = div_quo + {{(P-1){1'b0}}, 1'b1};
      default:
        rnd_mag = div_quo;
    endcase
    rnd_val  = neg_q ? -$signed(rnd_mag * `SCC_ONE) : $signed(rnd_mag * `SCC_ONE);
    step_val = neg_q ? -$signed(div_quo) : $signed(div_quo);
  end

  always @(posedge i_clk)
  begin
    if (i_reset)
    begin
      state_q     <= S_IDLE;
      neg_q       <= 1'b0;
      init_q      <= 1'b0;
      interp_q    <= {W{1'b0}};
      div_start_q <= 1'b0;
      div_num_q   <= {P{1'b0}};
      div_den_q   <= {P{1'b0}};
      o_curve_in  <= {W{1'b0}};
      o_curve_out <= {W{1'b0}};
      o_oor       <= 1'b0;
      o_update    <= 1'b0;
    end
    else
    begin
      div_start_q <= 1'b0;
      o_update    <= 1'b0;
      case (state_q)
        S_IDLE:
        begin
          if (!i_enable)
          begin
            init_q      <= 1'b0;
            o_curve_out <= {W{1'b0}};
            o_oor       <= 1'b0;
          end
          else if (tick_q)
          begin
            if (!i_in_valid)
            begin
              state_q <= S_SEG;
            end
            else if (i_filt_en && init_q)
            begin
              neg_q       <= filt_dif[P-1];
              div_num_q   <= fnum_w[P-1:0];
              div_den_q   <= tau_ext + dt_ext;
              div_start_q <= 1'b1;
              state_q     <= S_FILT;
            end
            else
            begin
              o_curve_in <= i_in_value;
              init_q     <= 1'b1;
              state_q    <= S_SEG;
            end
          end
        end
        S_FILT:
        begin
          if (div_done)
          begin
            o_curve_in <= o_curve_in + step_val[W-1:0];
            state_q    <= S_SEG;
          end
        end
        S_SEG:
        begin
          if (dxp == {P{1'b0}} || dx == {P{1'b0}})
          begin
            interp_q <= lo_out;
            state_q  <= S_RND;
          end
          else
          begin
            neg_q       <= prod[P-1] ^ dxp[P-1];
            div_num_q   <= mag(prod);
            div_den_q   <= mag(dxp);
            div_start_q <= 1'b1;
            state_q     <= S_INT;
          end
        end
        S_INT:
        begin
          if (div_done)
          begin
            interp_q <= lo_out + step_val[W-1:0];
            state_q  <= S_RND;
          end
        end
        S_RND:
        begin
          if (i_round_mode == `SCC_RND_FLOAT)
          begin
            state_q <= S_FIN;
          end
          else
          begin
            neg_q       <= interp_q[W-1];
            div_num_q   <= mag({{W{interp_q[W-1]}}, interp_q});
            div_den_q   <= `SCC_ONE;
            div_start_q <= 1'b1;
            state_q     <= S_RNDW;
          end
        end
        S_RNDW:
        begin
          if (div_done)
          begin
            interp_q <= rnd_val[W-1:0];
            state_q  <= S_FIN;
          end
        end
        S_FIN:
        begin
          o_curve_out <= interp_q;
          o_oor       <= i_oor_en &&
                         ((o_curve_in < i_min) ||
                          (o_curve_in > i_max));
          o_update    <= 1'b1;
          state_q     <= S_IDLE;
        end
        default:
        begin
          state_q <= S_IDLE;
        end
      endcase
    end
  end

endmodule

// file: bench/scc_meas.sv
// model of the measurement channel that feeds the curve input
`timescale 1ns/1ns
module scc_meas
(
  // clock and control from the bench
  input  wire                i_clk,
  input  wire                i_lost,
  input  wire signed [47:0]  i_value,
  // channel output
  output reg                 o_in_valid,
  output reg  signed [47:0]  o_in_value
);
  initial o_in_value = 48'h0;
  // a lost channel toggles between the complement of the last value and the last value
  always @(posedge i_clk)
  begin
    o_in_valid <= !i_lost;
    o_in_value <= i_lost ? ~o_in_value : i_value;
  end
endmodule

// file: bench/scc_top_asserts.sv
// concurrent checks on the scaled curve channel ports
`timescale 1ns/1ns
module scc_top_asserts
#(
  parameter W        = 48,
  parameter NPT      = 20,
  parameter STEP_CYC = 125000
)
(
  // clock and reset
  input wire                    i_clk,
  input wire                    i_reset,
  // configuration
  input wire                    i_enable,
  input wire                    i_filt_en,
  input wire                    i_oor_en,
  input wire [19:0]             i_tau_steps,
  input wire [10:0]             i_cycle_steps,
  input wire [1:0]              i_round_mode,
  input wire signed [W-1:0]     i_min,
  input wire signed [W-1:0]     i_max,
  // curve points
  input wire [NPT*W-1:0]        i_pt_in,
  input wire [NPT*W-1:0]        i_pt_out,
  input wire [NPT-1:0]          i_pt_used,
  // measured input
  input wire signed [W-1:0]     i_in_value,
  input wire                    i_in_valid,
  // indications
  input wire signed [W-1:0]     o_curve_in,
  input wire signed [W-1:0]     o_curve_out,
  input wire                    o_oor,
  input wire                    o_update
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_reset);
  // ----------------------------------------
  // spacing of updates
  // ----------------------------------------
  int   cnt_q;
  logic seen_q;
  int   per;
  assign per = int'(i_cycle_steps) * STEP_CYC;
  always @(posedge i_clk)
  begin
    if (i_reset || !i_enable)
    begin
      cnt_q  <= 0;
      seen_q <= 1'b0;
    end
    else if (o_update)
    begin
      cnt_q  <= 0;
      seen_q <= 1'b1;
    end
    else
      cnt_q <= cnt_q + 1;
  end
  // ----------------------------------------
  // properties
  // ----------------------------------------
  sequence s_off;
    !i_enable [*3];
  endsequence
  sequence s_pulse;
    o_update ##1 !o_update;
  endsequence
  property p_pulse;    o_update |-> s_pulse; endproperty
  property p_hold;     !o_update && i_enable |-> $stable(o_curve_out) && $stable(o_oor); endproperty
  property p_off;      s_off |-> o_curve_out == 0 && !o_oor && !o_update; endproperty
  // flag was computed one edge before the pulse is seen, so settings are taken from then
  property p_gate;     $rose(o_oor) |-> $past(i_oor_en); endproperty
  property p_low;      o_update && $past(i_oor_en) && o_curve_in < $past(i_min) |-> o_oor; endproperty
  property p_high;     o_update && $past(i_oor_en) && o_curve_in > $past(i_max) |-> o_oor; endproperty
  property p_inside;   o_update && o_curve_in >= $past(i_min) && o_curve_in <= $past(i_max) |-> !o_oor; endproperty
  property p_period;   o_update && seen_q |-> cnt_q + 1 >= per - 310 && cnt_q + 1 <= per + 310; endproperty
  property p_lost;     $changed(o_curve_in) |-> $past(i_in_valid); endproperty
  a_pulse:  assert property (p_pulse)  else $error("update pulse longer than one cycle");
  a_hold:   assert property (p_hold)   else $error("output moved between updates");
  a_off:    assert property (p_off)    else $error("disabled curve still drives output");
  a_gate:   assert property (p_gate)   else $error("flag raised while signalling off");
  a_low:    assert property (p_low)    else $error("flag missing below minimum");
  a_high:   assert property (p_high)   else $error("flag missing above maximum");
  a_inside: assert property (p_inside) else $error("flag set inside limits");
  a_period: assert property (p_period) else $error("update spacing wrong");
  a_lost:   assert property (p_lost)   else $error("input changed while lost");
endmodule

// file: bench/scc_top_test.sv
// self-checking bench for the scaled curve channel
`timescale 1ns/1ns
module scc_top_test;
  typedef struct packed {
    logic [47:0] x;
    logic [1:0]  m;
    logic [19:0] u;
    logic        e;
    logic [47:0] y;
    logic        f;
  } scc_row_t;
  logic               i_clk, i_reset, i_enable, i_filt_en, i_oor_en, i_lost, i_in_valid, o_oor, o_update;
  logic [19:0]        i_tau_steps, i_pt_used;
  logic [10:0]        i_cycle_steps;
  logic [1:0]         i_round_mode;
  logic signed [47:0] i_min, i_max, i_value, i_in_value, o_curve_in, o_curve_out;
  logic [959:0]       i_pt_in, i_pt_out;
  int                 err_total, samples_checked;
  // x, mode, used points, flag enable, expected out, expected flag
  scc_row_t rows [12] = '{
    '{48'hc350, 2'h0, 20'h0, 1'b1, 48'h7a120, 1'b0},
    '{48'h3039, 2'h0, 20'h0, 1'b1, 48'h1e23a, 1'b0},
    '{48'h3039, 2'h1, 20'h0, 1'b1, 48'h186a0, 1'b0},
    '{48'h3039, 2'h2, 20'h0, 1'b1, 48'h30d40, 1'b0},
    '{48'h3039, 2'h3, 20'h0, 1'b1, 48'h186a0, 1'b0},
    '{48'h3a98, 2'h3, 20'h0, 1'b1, 48'h30d40, 1'b0},
    '{48'hffff_ffff_cfc7, 2'h1, 20'h0, 1'b1, 48'hffff_fffc_f2c0, 1'b1},
    '{48'hffff_ffff_cfc7, 2'h2, 20'h0, 1'b1, 48'hffff_fffe_7960, 1'b1},
    '{48'h3d090, 2'h0, 20'h0, 1'b1, 48'h2625a0, 1'b1},
    '{48'h3d090, 2'h0, 20'h0, 1'b0, 48'h2625a0, 1'b0},
    '{48'h249f0, 2'h0, 20'h4, 1'b1, 48'hf4240, 1'b0},
    '{48'h30d40, 2'h0, 20'h4, 1'b1, 48'hf4240, 1'b0}};

  scc_top #(.STEP_CYC(250)) dut_u (.i_clk(i_clk), .i_reset(i_reset), .i_enable(i_enable), .i_filt_en(i_filt_en),
    .i_oor_en(i_oor_en), .i_tau_steps(i_tau_steps), .i_cycle_steps(i_cycle_steps), .i_round_mode(i_round_mode),
    .i_min(i_min), .i_max(i_max), .i_pt_in(i_pt_in), .i_pt_out(i_pt_out), .i_pt_used(i_pt_used),
    .i_in_value(i_in_value), .i_in_valid(i_in_valid), .o_curve_in(o_curve_in), .o_curve_out(o_curve_out),
    .o_oor(o_oor), .o_update(o_update));
  scc_meas meas_u (.i_clk(i_clk), .i_lost(i_lost), .i_value(i_value), .o_in_valid(i_in_valid),
    .o_in_value(i_in_value));

  initial
  begin
    i_clk = 1'b0;
    forever #20 i_clk = ~i_clk;
  end

  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
      err_total++;
    end
  endtask

  task automatic wait_upd;
    int n;
    n = 0;
    @(negedge i_clk);
    while (o_update !== 1'b1 && n < 1500)
    begin
      @(negedge i_clk);
      n++;
    end
    chk({47'h0, o_update}, 48'h1);
  endtask

  task automatic results;
    if (err_total == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  initial
  begin
    err_total = 0;
    samples_checked = 0;
    i_reset = 1'b1;
    i_enable = 1'b1;
    i_filt_en = 1'b0;
    i_oor_en = 1'b1;
    i_lost = 1'b0;
    i_tau_steps = 20'h4;
    i_cycle_steps = 11'h4;
    i_round_mode = 2'h0;
    i_min = 48'h0;
    i_max = 48'h30d40;
    i_value = 48'h0;
    i_pt_used = 20'h0;
    for (int k = 0; k < 20; k++)
    begin
      i_pt_in[k*48 +: 48] = 48'h186a0 * k;
      i_pt_out[k*48 +: 48] = (k == 2) ? 48'hf4240 : 48'hf4240 * k;
    end
    repeat (20) @(negedge i_clk);
    chk(o_curve_out, 48'h0);
    chk({47'h0, o_oor}, 48'h0);
    i_reset = 1'b0;
    // ----------------------------------------
    // table of ordinary cases
    // ----------------------------------------
    foreach (rows[r])
    begin
      i_value = rows[r].x;
      i_round_mode = rows[r].m;
      i_pt_used = rows[r].u;
      i_oor_en = rows[r].e;
      wait_upd;
      chk(o_curve_in, rows[r].x);
      chk(o_curve_out, rows[r].y);
      chk({47'h0, o_oor}, {47'h0, rows[r].f});
    end
    // ----------------------------------------
    // lost input, filter, disable
    // ----------------------------------------
    i_lost = 1'b1;
    i_value = 48'h7a120;
    wait_upd;
    chk(o_curve_in, 48'h30d40);
    chk(o_curve_out, 48'hf4240);
    i_lost = 1'b0;
    i_filt_en = 1'b1;
    i_value = 48'h0;
    wait_upd;
    chk(o_curve_in, 48'h186a0);
    wait_upd;
    chk(o_curve_in, 48'hc350);
    chk(o_curve_out, 48'h7a120);
    i_enable = 1'b0;
    repeat (5) @(negedge i_clk);
    chk(o_curve_out, 48'h0);
    i_enable = 1'b1;
    i_value = 48'h3d090;
    wait_upd;
    chk(o_curve_in, 48'h3d090);
    chk(o_curve_out, 48'hf4240);
    chk({47'h0, o_oor}, 48'h1);
    // ----------------------------------------
    // flag cleared when off, signed minimum
    // ----------------------------------------
    i_enable = 1'b0;
    i_filt_en = 1'b0;
    i_min = 48'hffff_fffe_7960;
    i_value = 48'hffff_ffff_3cb0;
    repeat (3) @(negedge i_clk);
    chk({47'h0, o_oor}, 48'h0);
    chk(o_curve_out, 48'h0);
    i_enable = 1'b1;
    wait_upd;
    chk(o_curve_in, 48'hffff_ffff_3cb0);
    chk(o_curve_out, 48'hffff_fff8_5ee0);
    chk({47'h0, o_oor}, 48'h0);
    results;
  end

  initial
  begin
    #1200000;
    err_total++;
    results;
  end
endmodule

bind scc_top scc_top_asserts #(.W(W), .NPT(NPT), .STEP_CYC(STEP_CYC)) chk_u (.i_clk(i_clk), .i_reset(i_reset),
  .i_enable(i_enable), .i_filt_en(i_filt_en), .i_oor_en(i_oor_en), .i_tau_steps(i_tau_steps),
  .i_cycle_steps(i_cycle_steps), .i_round_mode(i_round_mode), .i_min(i_min), .i_max(i_max), .i_pt_in(i_pt_in),
  .i_pt_out(i_pt_out), .i_pt_used(i_pt_used), .i_in_value(i_in_value), .i_in_valid(i_in_valid),
  .o_curve_in(o_curve_in), .o_curve_out(o_curve_out), .o_oor(o_oor), .o_update(o_update));
